//--- core/uesc_map.vh
// register offsets, field positions, codes and reset values for the endpoint status block
`ifndef UESC_MAP_VH
`define UESC_MAP_VH

`define UESC_EP_COUNT        8
`define UESC_EP_BITS         3

`define UESC_OFF_INDEX       3'h0
`define UESC_OFF_STATUS      3'h1
`define UESC_OFF_CONFIG      3'h2
`define UESC_OFF_IEN         3'h3

`define UESC_BIT_DIR         7
`define UESC_BIT_RSVD        6
`define UESC_BIT_STALL_REQUEST     5
`define UESC_BIT_TRANSMIT_PACKET_READY       4
`define UESC_BIT_STALL_SENT_OR_CRC_ERROR_FLAG      3
`define UESC_BIT_SETUP       2
`define UESC_BIT_OUT_RECEIVED_FLAG       1
`define UESC_BIT_TXCMP       0

`define UESC_FLAG_MSB        3
`define UESC_TYPE_MSB        1
`define UESC_TYPE_CONTROL    2'h0
`define UESC_TYPE_ISO        2'h1
`define UESC_TYPE_BULK       2'h2
`define UESC_TYPE_INTR       2'h3

`define UESC_RST_STATUS      8'h00
`define UESC_RST_INDEX       3'h0
`define UESC_RST_TYPE        2'h0
`define UESC_RST_IEN         8'h00

`endif

//--- core/uesc_ep_slice.v
// status and control bits of one endpoint
`timescale 1ns/1ps
`include "uesc_map.vh"

module uesc_ep_slice (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       sw_we_i,
	input  wire [7:0] sw_dat_i,
	input  wire [1:0] ep_type_i,
	input  wire       setup_i,
	input  wire       out_ok_i,
	input  wire       crc_err_i,
	input  wire       in_sent_i,
	input  wire       in_ack_i,
	input  wire       stall_sent_i,
	output reg  [7:0] status_o
);

	reg  [7:0] status_next;
	wire       is_iso;
	wire       is_ctrl;
	wire       in_done;

	assign is_iso  = (ep_type_i == `UESC_TYPE_ISO);
	assign is_ctrl = (ep_type_i == `UESC_TYPE_CONTROL);
	// iso frees the packet once sent, the others wait for the host ack
	assign in_done = is_iso ? in_sent_i : in_ack_i;

	always @* begin
		status_next = status_o;
		if (sw_we_i) begin
			// software writes stall and ready freely, direction only on control endpoints, and can only clear flags
			status_next[`UESC_BIT_DIR]     = sw_dat_i[`UESC_BIT_DIR] & is_ctrl;
			status_next[`UESC_BIT_STALL_REQUEST] = sw_dat_i[`UESC_BIT_STALL_REQUEST];
			status_next[`UESC_BIT_TRANSMIT_PACKET_READY]   = sw_dat_i[`UESC_BIT_TRANSMIT_PACKET_READY];
			status_next[`UESC_FLAG_MSB:0]  = status_o[`UESC_FLAG_MSB:0] & sw_dat_i[`UESC_FLAG_MSB:0];
		end
		if (in_done) begin
			status_next[`UESC_BIT_TRANSMIT_PACKET_READY] = 1'b0;
			status_next[`UESC_BIT_TXCMP] = 1'b1;
		end
		if (is_iso) begin
			if (crc_err_i) begin
				status_next[`UESC_BIT_STALL_SENT_OR_CRC_ERROR_FLAG] = 1'b1;
			end else if (out_ok_i) begin
				status_next[`UESC_BIT_STALL_SENT_OR_CRC_ERROR_FLAG] = 1'b0;
			end
		end else if (stall_sent_i && status_o[`UESC_BIT_STALL_REQUEST]) begin
			status_next[`UESC_BIT_STALL_SENT_OR_CRC_ERROR_FLAG] = 1'b1;
		end
		if (out_ok_i) begin
			status_next[`UESC_BIT_OUT_RECEIVED_FLAG] = 1'b1;
		end
		// setup outranks everything else in the same cycle
		if (setup_i && is_ctrl) begin
			status_next = `UESC_RST_STATUS;
			status_next[`UESC_BIT_SETUP] = 1'b1;
		end
		status_next[`UESC_BIT_RSVD] = 1'b0;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			status_o <= `UESC_RST_STATUS;
		end else begin
			status_o <= status_next;
		end
	end

endmodule // uesc_ep_slice

//--- core/uesc_top.v
// endpoint status and control register block with a wishbone slave
// Notes on behaviour
// - accesses reach only the indexed endpoint
// - direction bit only matters for control endpoints
// - direction bit also sets status-phase direction
// - bit six reads zero, never write one
// - stall request makes next handshake a stall
// - transmit ready with empty fifo sends zlp
// - transmit ready clears on send or ack
// - stall sent sets flag three, interrupts
// - setup clears the stall sent flag
// - iso: flag three marks crc error
// - iso: clean data clears crc error flag
// - accepted out packet sets out flag
// - out flag set means further outs nak
// - control setup may overwrite fifo anyway
// - setup sets its flag, clears the rest
// - in complete flag set after transmission
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "uesc_map.vh"

module uesc_top (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [4:2]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	input  wire [2:0]  evt_ep_i,
	input  wire        setup_rx_i,
	input  wire        out_rx_i,
	input  wire        crc_err_i,
	input  wire        in_sent_i,
	input  wire        in_ack_i,
	input  wire        stall_sent_i,
	input  wire [7:0]  fifo_empty_i,
	output reg  [7:0]  ep_stall_o,
	output reg  [7:0]  ep_tx_ready_o,
	output reg  [7:0]  ep_tx_zlp_o,
	output reg  [7:0]  ep_out_nak_o,
	output reg  [7:0]  ep_setup_accept_o,
	output reg  [7:0]  ep_status_in_o,
	output reg  [7:0]  ep_int_o
);

	localparam N = `UESC_EP_COUNT;

	reg  [2:0]     index_reg;
	reg  [2:0]     index_next;
	reg  [2*N-1:0] type_reg;
	reg  [2*N-1:0] type_next;
	reg  [7:0]     ien_reg;
	reg  [7:0]     ien_next;
	reg  [31:0]    rdata_next;
	wire [8*N-1:0] status_all;
	wire           bus_req;
	wire           wr_low;
	wire [7:0]     sel_status;
	wire [1:0]     sel_type;

	// one answer per request; masking the request while ack is high stops a double take
	assign bus_req = cyc_i & stb_i & ~ack_o;
	assign wr_low  = bus_req & we_i & sel_i[0];

	function hit;
		input [2:0] ep;
		input integer i;
		begin
			hit = (ep == i[2:0]);
		end
	endfunction

	function [7:0] status_of;
		input [8*N-1:0] all;
		input [2:0]     ep;
		begin
			status_of = all[ep*8 +: 8];
		end
	endfunction

	function [1:0] type_of;
		input [2*N-1:0] all;
		input [2:0]     ep;
		begin
			type_of = all[ep*2 +: 2];
		end
	endfunction

	assign sel_status = status_of(status_all, index_reg);
	assign sel_type   = type_of(type_reg, index_reg);

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : ep
			wire sw_we;
			wire ev;
			// writes land only on the indexed endpoint
			assign sw_we = wr_low & (adr_i == `UESC_OFF_STATUS) & hit(index_reg, g);
			assign ev    = hit(evt_ep_i, g);
			uesc_ep_slice u_slice (
				.clk_i        (clk_i),
				.rst_i        (rst_i),
				.sw_we_i      (sw_we),
				.sw_dat_i     (dat_i[7:0]),
				.ep_type_i    (type_reg[g*2 +: 2]),
				.setup_i      (ev & setup_rx_i),
				.out_ok_i     (ev & out_rx_i),
				.crc_err_i    (ev & crc_err_i),
				.in_sent_i    (ev & in_sent_i),
				.in_ack_i     (ev & in_ack_i),
				.stall_sent_i (ev & stall_sent_i),
				.status_o     (status_all[g*8 +: 8])
			);
		end
	endgenerate

	always @* begin
		index_next = index_reg;
		type_next  = type_reg;
		ien_next   = ien_reg;
		if (wr_low) begin
			case (adr_i)
				`UESC_OFF_INDEX: begin
					index_next = dat_i[2:0];
				end
				`UESC_OFF_CONFIG: begin
					type_next[index_reg*2 +: 2] = dat_i[`UESC_TYPE_MSB:0];
				end
				`UESC_OFF_IEN: begin
					ien_next = dat_i[7:0];
				end
				default: begin
					index_next = index_reg;
				end
			endcase
		end
	end

	always @* begin
		rdata_next = 32'h0000_0000;
		case (adr_i)
			`UESC_OFF_INDEX: begin
				rdata_next[2:0] = index_reg;
			end
			`UESC_OFF_STATUS: begin
				rdata_next[7:0] = sel_status;
			end
			`UESC_OFF_CONFIG: begin
				rdata_next[`UESC_TYPE_MSB:0] = sel_type;
			end
			`UESC_OFF_IEN: begin
				rdata_next[7:0] = ien_reg;
			end
			default: begin
				rdata_next = 32'h0000_0000;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			index_reg <= `UESC_RST_INDEX;
			type_reg  <= {N{`UESC_RST_TYPE}};
			ien_reg   <= `UESC_RST_IEN;
			ack_o     <= 1'b0;
			dat_o     <= 32'h0000_0000;
		end else begin
			index_reg <= index_next;
			type_reg  <= type_next;
			ien_reg   <= ien_next;
			ack_o     <= bus_req;
			if (bus_req && !we_i) begin
				dat_o <= rdata_next;
			end
		end
	end

	// link-facing view of every endpoint, one cycle behind the register bits
	integer i;
	always @(posedge clk_i) begin
		if (rst_i) begin
			ep_stall_o        <= 8'h00;
			ep_tx_ready_o     <= 8'h00;
			ep_tx_zlp_o       <= 8'h00;
			ep_out_nak_o      <= 8'h00;
			ep_setup_accept_o <= 8'h00;
			ep_status_in_o    <= 8'h00;
			ep_int_o          <= 8'h00;
		end else begin
			for (i = 0; i < N; i = i + 1) begin
				ep_stall_o[i]    <= status_all[i*8 + `UESC_BIT_STALL_REQUEST];
				ep_tx_ready_o[i] <= status_all[i*8 + `UESC_BIT_TRANSMIT_PACKET_READY];
				// an empty fifo with ready set goes out as a zero-length packet
				ep_tx_zlp_o[i]   <= status_all[i*8 + `UESC_BIT_TRANSMIT_PACKET_READY] & fifo_empty_i[i];
				ep_out_nak_o[i]  <= status_all[i*8 + `UESC_BIT_OUT_RECEIVED_FLAG];
				// control setups are taken even while out data is pending
				ep_setup_accept_o[i] <= (type_reg[i*2 +: 2] == `UESC_TYPE_CONTROL);
				// data stage set means status stage runs the other way
				ep_status_in_o[i] <= (type_reg[i*2 +: 2] == `UESC_TYPE_CONTROL) &
					~status_all[i*8 + `UESC_BIT_DIR];
				ep_int_o[i] <= ien_reg[i] & (|status_all[i*8 +: 4]);
			end
		end
	end

endmodule // uesc_top

//--- verification/uesc_props_properties.sv
// assertions on the endpoint status block ports
`timescale 1ns/1ps
module uesc_props (
	input wire        clk_i,
	input wire        rst_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        we_i,
	input wire [4:2]  adr_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire [2:0]  evt_ep_i,
	input wire        setup_rx_i,
	input wire        out_rx_i,
	input wire        in_ack_i,
	input wire [7:0]  fifo_empty_i,
	input wire [7:0]  ep_stall_o,
	input wire [7:0]  ep_tx_ready_o,
	input wire [7:0]  ep_tx_zlp_o,
	input wire [7:0]  ep_out_nak_o,
	input wire [7:0]  ep_setup_accept_o,
	input wire [7:0]  ep_status_in_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not answered");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	rsvd_zero_a: assert property (ack_o && !we_i && adr_i == 3'h1 |-> dat_o[31:8] == 24'h0 && !dat_o[6])
		else $error("reserved status bits read nonzero");
	setup_clear_a: assert property (setup_rx_i && ep_setup_accept_o[evt_ep_i] |->
		##2 (((ep_stall_o | ep_tx_ready_o | ep_out_nak_o) >> $past(evt_ep_i, 2)) & 8'h01) == 8'h00)
		else $error("setup left other bits set");
	out_nak_a: assert property (out_rx_i && !setup_rx_i |-> ##2 ep_out_nak_o[$past(evt_ep_i, 2)])
		else $error("accepted out packet did not raise nak");
	zlp_follow_a: assert property (ep_tx_zlp_o == (ep_tx_ready_o & $past(fifo_empty_i)))
		else $error("zero length request wrong");
	transmit_packet_ready_clear_a: assert property (in_ack_i && !setup_rx_i && ep_setup_accept_o[evt_ep_i] |->
		##2 !ep_tx_ready_o[$past(evt_ep_i, 2)])
		else $error("ack did not clear transmit ready");
	status_in_a: assert property ((ep_status_in_o & ~ep_setup_accept_o) == 8'h00)
		else $error("status direction on non control endpoint");
endmodule // uesc_props

bind uesc_top uesc_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .evt_ep_i,
	.setup_rx_i, .out_rx_i, .in_ack_i, .fifo_empty_i, .ep_stall_o, .ep_tx_ready_o, .ep_tx_zlp_o,
	.ep_out_nak_o, .ep_setup_accept_o, .ep_status_in_o);

//--- verification/uesc_host_model.sv
// behavioural usb host giving one-cycle link event pulses
`timescale 1ns/1ps
module uesc_host_model (
	input  wire       clk_i,
	output reg  [2:0] evt_ep_o,
	output reg  [5:0] ev_o
);
	// ev_o order: setup, out, crc error, in sent, in ack, stall sent
	initial begin
		evt_ep_o = 3'h0;
		ev_o = 6'h00;
	end
	// idle endpoint shows the inverse so a stale number never matches
	task send(input [5:0] e, input [2:0] ep);
		begin
			@(posedge clk_i);
			ev_o <= e;
			evt_ep_o <= ep;
			@(posedge clk_i);
			ev_o <= 6'h00;
			evt_ep_o <= ~ep;
		end
	endtask
endmodule // uesc_host_model

//--- verification/uesc_top_tb.sv
// self-checking bench for the endpoint status block
`timescale 1ns/1ps
module uesc_top_tb;
	reg         clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg         cyc = 1'b0;
	reg         stb = 1'b0;
	reg         we = 1'b0;
	reg  [2:0]  adr = 3'h0;
	reg  [7:0]  wd = 8'h00;
	reg  [7:0]  fe = 8'h02;
	reg  [7:0]  q;
	wire [31:0] dat_o;
	wire        ack;
	wire [2:0]  ev_ep;
	wire [5:0]  ev;
	wire [7:0]  stall, txr, zlp, nak, sacc, sin, intr;
	integer     mismatches = 0;
	integer     num_checks = 0;
	uesc_host_model host (.clk_i(clk_i), .evt_ep_o(ev_ep), .ev_o(ev));
	uesc_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1),
		.dat_i({24'h0, wd}), .dat_o(dat_o), .ack_o(ack), .evt_ep_i(ev_ep), .setup_rx_i(ev[5]), .out_rx_i(ev[4]),
		.crc_err_i(ev[3]), .in_sent_i(ev[2]), .in_ack_i(ev[1]), .stall_sent_i(ev[0]), .fifo_empty_i(fe),
		.ep_stall_o(stall), .ep_tx_ready_o(txr), .ep_tx_zlp_o(zlp), .ep_out_nak_o(nak),
		.ep_setup_accept_o(sacc), .ep_status_in_o(sin), .ep_int_o(intr));
	initial forever #5 clk_i = ~clk_i;
	task ck(input [63:0] n, input [7:0] e, input [7:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("mismatch %0s exp %h got %h", n, e, g);
			end
		end
	endtask
	// classic wishbone cycle; waits for ack however long it takes
	task acc(input w, input [2:0] a, input [7:0] d);
		begin
			@(posedge clk_i);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			wd <= d;
			@(posedge clk_i);
			while (ack !== 1'b1) @(posedge clk_i);
			q = dat_o[7:0];
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask
	task rs(input [2:0] ep, input [7:0] e);
		begin
			acc(1'b1, 3'h0, ep);
			acc(1'b0, 3'h1, 8'h00);
			ck("status", e, q);
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", num_checks, mismatches);
			if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		#100000;
		mismatches = mismatches + 1;
		summarize;
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rs(3'h0, 8'h00);
		acc(1'b0, 3'h3, 8'h00);
		ck("ien", 8'h00, q);
		acc(1'b1, 3'h0, 8'h01);
		acc(1'b1, 3'h1, 8'h30);
		rs(3'h0, 8'h00);
		rs(3'h1, 8'h30);
		ck("stall", 8'h02, stall);
		ck("txr", 8'h02, txr);
		ck("zlp", 8'h02, zlp);
		ck("sacc", 8'hff, sacc);
		rs(3'h0, 8'h00);
		// bit six is never written as one, only checked to read zero
		acc(1'b1, 3'h1, 8'h80);
		acc(1'b0, 3'h1, 8'h00);
		ck("dir", 8'h80, q);
		ck("stsin", 8'hfe, sin);
		acc(1'b1, 3'h1, 8'h00);
		$display("test index and fields done");
		host.send(6'h04, 3'h1);
		rs(3'h1, 8'h30);
		host.send(6'h02, 3'h1);
		rs(3'h1, 8'h21);
		host.send(6'h01, 3'h1);
		rs(3'h1, 8'h29);
		acc(1'b1, 3'h3, 8'h02);
		@(posedge clk_i);
		ck("int", 8'h02, intr);
		host.send(6'h20, 3'h1);
		rs(3'h1, 8'h04);
		ck("stall", 8'h00, stall);
		acc(1'b1, 3'h1, 8'h84);
		rs(3'h1, 8'h84);
		ck("stsin", 8'hfd, sin);
		acc(1'b1, 3'h1, 8'h00);
		rs(3'h1, 8'h00);
		$display("test control in done");
		acc(1'b1, 3'h0, 8'h02);
		acc(1'b1, 3'h2, 8'h02);
		acc(1'b1, 3'h1, 8'h80);
		rs(3'h2, 8'h00);
		host.send(6'h10, 3'h2);
		rs(3'h2, 8'h02);
		fork
			host.send(6'h10, 3'h2);
			acc(1'b1, 3'h1, 8'h00);
		join
		rs(3'h2, 8'h02);
		ck("nak", 8'h04, nak);
		acc(1'b1, 3'h1, 8'h00);
		rs(3'h2, 8'h00);
		// a setup aimed at a bulk endpoint must leave it untouched
		host.send(6'h20, 3'h2);
		rs(3'h2, 8'h00);
		$display("test bulk out done");
		acc(1'b1, 3'h0, 8'h03);
		acc(1'b1, 3'h2, 8'h01);
		host.send(6'h08, 3'h3);
		rs(3'h3, 8'h08);
		host.send(6'h10, 3'h3);
		rs(3'h3, 8'h02);
		acc(1'b1, 3'h1, 8'h10);
		host.send(6'h04, 3'h3);
		rs(3'h3, 8'h01);
		ck("sacc", 8'hf3, sacc);
		acc(1'b0, 3'h5, 8'h00);
		ck("unmapped", 8'h00, q);
		$display("test iso done");
		summarize;
	end
endmodule // uesc_top_tb
